/* bench/i2c_receive_handshake_ctrl_tb_top.sv */
// Purpose: register and link level test of i2rh_top
// Assumes: device receives every byte except the one sent in transmit mode, master model drives SCL
// Notes:   register offsets from i2rh_defines.svh
`include "i2rh_defines.svh"

module i2c_receive_handshake_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic        scl_out, scl_oe, sda_out, sda_oe, irq, scl_m, sda_m;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  wire logic   scl_w = scl_m & (scl_oe ? scl_out : 1'b1);
  wire logic   sda_w = sda_m & (sda_oe ? sda_out : 1'b1);
  int          error_cnt, tests_run;

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  i2rh_top #(.AW(8)) i_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  i2rh_mst i_mst (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));

  // ----
  // Tasks
  // ----
  task automatic stop_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask

  task automatic byte_in(input logic [7:0] d);
    i_mst.put_byte(d);
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    error_cnt = 0;
    tests_run = 0;
    pause(4);
    resetn <= 1'b1;
    pause(3);
    rdc("ext_reset", `I2RH_OFF_EXT_CTRL, 32'h0, 32'hFF);
    rdc("clr_read", `I2RH_OFF_LATCH_CLR, 32'hF, 32'hF);
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    wr(`I2RH_OFF_EXT_CTRL, 32'hFF);
    rdc("ext_ro", `I2RH_OFF_EXT_CTRL, 32'hC0, 32'hFF);
    wr(`I2RH_OFF_CTRL, 32'h1);
    wr(`I2RH_OFF_IRQ_MASK, 32'h3);
    wr(`I2RH_OFF_EXT_CTRL, 32'h40);
    i_mst.start();
    byte_in(8'hA5);
    chk("hold", 32'h1, {31'h0, scl_oe});
    chk("irq_rx", 32'h1, {31'h0, irq});
    rdc("ready", `I2RH_OFF_EXT_CTRL, 32'h60, 32'hFF);
    rdc("data", `I2RH_OFF_DATA, 32'hA5, 32'hFF);
    pause(2);
    chk("release", 32'h0, {31'h0, scl_oe});
    rdc("ready_clr", `I2RH_OFF_EXT_CTRL, 32'h40, 32'hFF);
    wr(`I2RH_OFF_EXT_CTRL, 32'h0);
    byte_in(8'h3C);
    chk("no_hold", 32'h0, {31'h0, scl_oe});
    byte_in(8'hC3);
    rdc("first", `I2RH_OFF_DATA, 32'h3C, 32'hFF);
    rdc("refill", `I2RH_OFF_EXT_CTRL, 32'h20, 32'hFF);
    rdc("pending", `I2RH_OFF_DATA, 32'hC3, 32'hFF);
    rdc("empty", `I2RH_OFF_EXT_CTRL, 32'h0, 32'hFF);
    wr(`I2RH_OFF_IRQ_STAT, 32'h3);
    i_mst.stop();
    pause(4);
    rdc("stop_flag", `I2RH_OFF_IRQ_STAT, 32'h1, 32'h3);
    chk("irq_stop", 32'h1, {31'h0, irq});
    wr(`I2RH_OFF_IRQ_MASK, 32'h0);
    pause(1);
    chk("irq_gate", 32'h0, {31'h0, irq});
    wr(`I2RH_OFF_IRQ_MASK, 32'h3);
    wr(`I2RH_OFF_IRQ_STAT, 32'h3);
    wr(`I2RH_OFF_EXT_CTRL, 32'h80);
    i_mst.start();
    i_mst.stop();
    pause(4);
    rdc("masked", `I2RH_OFF_IRQ_STAT, 32'h0, 32'h3);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`I2RH_OFF_CTRL, 32'h3);
    wr(`I2RH_OFF_EXT_CTRL, 32'h40);
    i_mst.start();
    byte_in(8'h5A);
    chk("tx_hold", 32'h0, {31'h0, scl_oe});
    rdc("tx_ready", `I2RH_OFF_EXT_CTRL, 32'h40, 32'hFF);
    i_mst.stop();
    for (int i = 0; i < 3; i++) begin
      wr(`I2RH_OFF_CTRL, 32'h1);
      wr(`I2RH_OFF_EXT_CTRL, 32'h40);
      i_mst.start();
      byte_in(8'h11 + 8'(i));
      rdc("pre_clr", `I2RH_OFF_EXT_CTRL, 32'h20, 32'h20);
      if (i == 0)
        wr(`I2RH_OFF_CTRL, 32'h0);
      else
        wr(`I2RH_OFF_LATCH_CLR, (i == 1) ? 32'h5 : 32'h7);
      pause(3);
      chk("clr_hold", 32'h0, {31'h0, scl_oe});
      rdc("clr_ready", `I2RH_OFF_EXT_CTRL, 32'h0, 32'h20);
      i_mst.stop();
    end
    chk("scl_stuck", 32'h0, 32'(i_mst.stuck_cnt));
    chk("acks", 32'h6, 32'(i_mst.ack_cnt));
    stop_test();
  end

  initial begin
    #5000000;
    error_cnt++;
    stop_test();
  end
endmodule

/* bench/i2rh_asserts.sv */
// Purpose: port checks on i2rh_top
// Assumes: zero-wait APB, bench SCL low phase of 4 clocks
// Notes:   bound to every i2rh_top instance
`include "i2rh_defines.svh"

module i2rh_chk #(
  parameter int AW = 8
) (
  // System
  input wire logic          clk_sys,
  input wire logic          resetn,
  // APB
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // Pins
  input wire logic          scl_in,
  input wire logic          scl_out,
  input wire logic          scl_oe,
  input wire logic          sda_in,
  input wire logic          sda_out,
  input wire logic          sda_oe,
  input wire logic          irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Decode
  // ----
  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire rd_data = acc && !pwrite && paddr == `I2RH_OFF_DATA;
  wire rd_clr  = psel && !penable && !pwrite && paddr == `I2RH_OFF_LATCH_CLR;
  wire miss    = paddr > AW'(`I2RH_OFF_LATCH_CLR) || paddr[1:0] != 2'h0;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_clr_reads_ones: assert property (rd_clr |=> prdata[3:0] == 4'hF)
    else $error("latch clear read not all ones");
  a_unmapped_err: assert property (acc && miss |-> pslverr)
    else $error("unmapped access without slave error");
  a_read_releases: assert property (rd_data && scl_oe |=> !scl_oe)
    else $error("data read did not release SCL");
  a_hold_stands: assert property (scl_oe && !acc |=> scl_oe)
    else $error("SCL hold dropped without an access");
  a_off_drops: assert property (wr && paddr == `I2RH_OFF_CTRL && !pwdata[0]
    |=> !scl_oe && !sda_oe)
    else $error("disable left a pin driven");
  a_clr_drops: assert property (wr && paddr == `I2RH_OFF_LATCH_CLR
    && pwdata[3:0] == 4'h5 |-> ##[1:3] !scl_oe)
    else $error("latch clear left SCL held");
  a_tx_no_ack: assert property (wr && paddr == `I2RH_OFF_CTRL && pwdata[1]
    |=> (!sda_oe)[*4])
    else $error("acknowledge driven in transmit mode");
  a_mask_irq_off: assert property (wr && paddr == `I2RH_OFF_IRQ_MASK
    && pwdata[1:0] == 2'h0 |=> !irq)
    else $error("interrupt with all sources masked");
  a_ack_window: assert property ($rose(sda_oe) |-> (sda_oe || wr)[*6])
    else $error("acknowledge slot cut short");

  c_hold_read: cover property (rd_data && scl_oe);
  c_irq: cover property ($rose(irq));
  c_ack: cover property ($rose(sda_oe));
endmodule

bind i2rh_top i2rh_chk #(.AW(AW)) i_chk (
  .clk_sys (clk_sys),
  .resetn  (resetn),
  .psel    (psel),
  .penable (penable),
  .pwrite  (pwrite),
  .paddr   (paddr),
  .pwdata  (pwdata),
  .prdata  (prdata),
  .pready  (pready),
  .pslverr (pslverr),
  .scl_in  (scl_in),
  .scl_out (scl_out),
  .scl_oe  (scl_oe),
  .sda_in  (sda_in),
  .sda_out (sda_out),
  .sda_oe  (sda_oe),
  .irq     (irq)
);

/* bench/i2rh_mst.sv */
// Purpose: behavioural bus master sending bytes to the slave
// Assumes: open-drain wires with pull-ups, 400 ns SCL period
// Notes:   waits out clock stretching, bounded
module i2rh_mst (
  // Bus wires
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_m,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 1ns;
  int stuck_cnt;
  int ack_cnt;

  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    stuck_cnt = 0;
    ack_cnt = 0;
  end

  // Releases SCL and honours a slave that stretches it
  task automatic rise();
    int n;
    n = 0;
    scl_m = 1'b1;
    while (scl_w !== 1'b1 && n < 400) begin
      #50;
      n++;
    end
    if (scl_w !== 1'b1)
      stuck_cnt++;
    #200;
  endtask

  task automatic put_bit(input logic b);
    scl_m = 1'b0;
    #100 sda_m = b;
    #100 rise();
  endtask

  // Off the 100 ns grid so pin edges miss clk_sys edges until the bench next waits on a clock
  task automatic start();
    #10 sda_m = 1'b1;
    #200 sda_m = 1'b0;
    #200;
  endtask

  task automatic put_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    put_bit(1'b1);
    // Slave still pulls SDA low while the ninth clock is high
    if (sda_w === 1'b0)
      ack_cnt++;
    scl_m = 1'b0;
  endtask

  task automatic stop();
    scl_m = 1'b0;
    #100 sda_m = 1'b0;
    #100 rise();
    sda_m = 1'b1;
    #200;
  endtask
endmodule

/* hw/i2rh_bit_rx.sv */
// Purpose: bus condition detection and bit shifting
// Assumes: scl and sda already synchronised to clk_sys
// Notes:   byte_done pulses on the ninth rising scl edge
`include "i2rh_defines.svh"

module i2rh_bit_rx
  import i2rh_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       clr,
  // Synchronised bus lines
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  // Events and data
  output logic            start_det,
  output logic            stop_det,
  output logic            scl_fall,
  output logic            byte_done,
  output logic            ack_drive,
  output i2rh_byte_t      shift_reg
);

  logic       scl_d;
  logic       sda_d;
  logic       active;
  logic [3:0] bit_cnt;
  wire        scl_rise = scl_s & ~scl_d;
  wire        last_bit = (bit_cnt == `I2RH_ACK_BIT);

  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s & active;
  assign byte_done = scl_rise & active & last_bit;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active    <= 1'b0;
      bit_cnt   <= 4'h0;
      shift_reg <= `I2RH_RST_BYTE;
      ack_drive <= 1'b0;
    end else if (clr || stop_det) begin
      active    <= 1'b0;
      bit_cnt   <= 4'h0;
      ack_drive <= 1'b0;
    end else if (start_det) begin
      active  <= 1'b1;
      bit_cnt <= 4'h0;
    end else if (scl_rise && active) begin
      if (!last_bit) begin
        shift_reg <= {shift_reg[6:0], sda_s};
      end
      bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
    end else if (scl_fall && active) begin
      // Acknowledge slot spans the ninth clock low to low
      ack_drive <= last_bit;
    end
  end

endmodule

/* hw/i2rh_defines.svh */
`ifndef I2RH_DEFINES_SVH
`define I2RH_DEFINES_SVH

// Register byte offsets
`define I2RH_OFF_DATA      8'h00
`define I2RH_OFF_EXT_CTRL  8'h04
`define I2RH_OFF_CTRL      8'h08
`define I2RH_OFF_IRQ_STAT  8'h0C
`define I2RH_OFF_IRQ_MASK  8'h10
`define I2RH_OFF_LATCH_CLR 8'h14

// Extended control fields
`define I2RH_XC_STOP_MASK  7
`define I2RH_XC_HANDSHAKE  6
`define I2RH_XC_RX_READY   5

// Control fields
`define I2RH_CT_ENABLE     0
`define I2RH_CT_TX_MODE    1
`define I2RH_CT_SCL_HELD   7

// Interrupt status fields
`define I2RH_IS_IFACE      0
`define I2RH_IS_RX_DONE    1

// Reset values
`define I2RH_RST_BYTE      8'h00
`define I2RH_RST_IRQ       2'h0

// Latch clear codes and read-back
`define I2RH_CLR_CODE_A    4'h5
`define I2RH_CLR_CODE_B    4'h7
`define I2RH_CLR_READBACK  4'hF

// Bit count of the ninth clock (zero based)
`define I2RH_ACK_BIT       4'h8

`endif

/* hw/i2rh_pkg.sv */
// Purpose: types shared by the receive handshake controller
// Assumes: one-hot state encoding
// Notes:   constants live in i2rh_defines.svh
package i2rh_pkg;

  typedef enum logic [2:0] {
    I2RH_ST_RUN  = 3'b001,
    I2RH_ST_ARM  = 3'b010,
    I2RH_ST_HOLD = 3'b100
  } i2rh_state_e;

  typedef logic [7:0] i2rh_byte_t;

endpackage

/* hw/i2rh_sync.sv */
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   first stage is read only by the second
module i2rh_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '1;
      dout <= '1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

/* hw/i2rh_top.sv */
// Purpose: receive handshake controller of a two-wire slave
// Assumes: APB slave, zero wait, scl and sda from pins
// Notes:
// Notes on behaviour
// - Unmasked slave stop sets interface interrupt flag
// - Masked stop sets no flag, no interrupt
// - Extended control bit 6 enables handshake
// - Handshake off, buffer empty: keep clocking
// - Handshake on, receive mode: hold SCL low after byte
// - Data register read releases held SCL
// - Ready flag bit 5, read-only, resets 0
// - Empty buffer: transfer on ninth clock rise
// - Pending byte transfers on receive-mode read
// - Read clears flag unless a pending or new byte refills it same cycle
// - Read, enable clear, latch clear drop flag
// - Transmit mode never fills receive buffer
// - Latch clear write of code 5 or 7 pulses init, reads ones
`include "i2rh_defines.svh"

module i2rh_top
  import i2rh_pkg::*;
#(
  parameter int AW = 8
) (
  // System
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Bus pins
  input  wire logic          scl_in,
  output logic               scl_out,
  output logic               scl_oe,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe,
  // Interrupt
  output logic               irq
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------
  // Pin synchronisers and bit receiver
  // ----------------------------------------
  logic [1:0] pins_s;
  logic       start_det;
  logic       stop_det;
  logic       scl_fall;
  logic       byte_done;
  logic       ack_drive;
  i2rh_byte_t shift_reg;
  logic       rx_clr;

  i2rh_sync #(.W(2)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({scl_in, sda_in}),
    .dout    (pins_s)
  );

  i2rh_bit_rx u_bit_rx (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .clr       (rx_clr),
    .scl_s     (pins_s[1]),
    .sda_s     (pins_s[0]),
    .start_det (start_det),
    .stop_det  (stop_det),
    .scl_fall  (scl_fall),
    .byte_done (byte_done),
    .ack_drive (ack_drive),
    .shift_reg (shift_reg)
  );

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic        stop_irq_mask;
  logic        rx_handshake_en;
  logic        rx_data_ready_flag;
  logic        module_enable_bit;
  logic        tx_rx_select;
  logic        rx_pending;
  i2rh_byte_t  rx_buffer;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  i2rh_state_e state;
  i2rh_state_e next_state;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  function automatic logic reg_hit(input logic [AW-1:0] a, input logic [7:0] off);
    reg_hit = (a == AW'(off));
  endfunction

  wire apb_setup  = psel & ~penable;
  wire apb_access = psel & penable;
  wire wr_en      = apb_access & pwrite;
  wire rd_en      = apb_access & ~pwrite;

  wire hit_data  = reg_hit(paddr, `I2RH_OFF_DATA);
  wire hit_xc    = reg_hit(paddr, `I2RH_OFF_EXT_CTRL);
  wire hit_ctrl  = reg_hit(paddr, `I2RH_OFF_CTRL);
  wire hit_stat  = reg_hit(paddr, `I2RH_OFF_IRQ_STAT);
  wire hit_mask  = reg_hit(paddr, `I2RH_OFF_IRQ_MASK);
  wire hit_lclr  = reg_hit(paddr, `I2RH_OFF_LATCH_CLR);
  wire mapped    = hit_data | hit_xc | hit_ctrl | hit_stat | hit_mask | hit_lclr;

  assign pready  = 1'b1;
  assign pslverr = apb_access & ~mapped;

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  wire rx_mode    = ~tx_rx_select;
  wire data_rd    = rd_en & hit_data;
  // Only the documented clear codes act; other patterns are ignored
  wire clr_code   = (pwdata[3:0] == `I2RH_CLR_CODE_A) | (pwdata[3:0] == `I2RH_CLR_CODE_B);
  wire latch_clr  = wr_en & hit_lclr & clr_code;
  wire enable_off = wr_en & hit_ctrl & ~pwdata[`I2RH_CT_ENABLE];
  wire init_clr   = latch_clr | enable_off;
  wire got_byte   = byte_done & rx_mode & module_enable_bit;
  // A read in the same cycle frees the buffer, or the byte would strand
  wire xfer_now   = got_byte & (~rx_data_ready_flag | data_rd);
  wire pend_set   = got_byte & rx_data_ready_flag & ~data_rd;
  wire pend_xfer  = data_rd & rx_pending & rx_mode;
  // A full buffer always stalls, or the pending byte would be overrun
  wire hold_req   = got_byte & (rx_handshake_en | rx_data_ready_flag);
  wire stop_evt   = stop_det & module_enable_bit & ~stop_irq_mask;

  assign rx_clr = init_clr | ~module_enable_bit;

  // ----------------------------------------
  // Receive buffer and ready flag
  // ----------------------------------------
  logic next_flag;
  logic next_pending;

  always_comb begin
    next_flag    = rx_data_ready_flag;
    next_pending = rx_pending;
    if (data_rd) begin
      next_flag = 1'b0;
    end
    if (xfer_now || pend_xfer) begin
      next_flag = 1'b1;
    end
    if (pend_set) begin
      next_pending = 1'b1;
    end else if (pend_xfer) begin
      next_pending = 1'b0;
    end
    if (init_clr) begin
      next_flag    = 1'b0;
      next_pending = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_ready_flag <= 1'b0;
      rx_pending         <= 1'b0;
      rx_buffer          <= `I2RH_RST_BYTE;
    end else begin
      rx_data_ready_flag <= next_flag;
      rx_pending         <= next_pending;
      if ((xfer_now || pend_xfer) && !init_clr) begin
        rx_buffer <= shift_reg;
      end
    end
  end

  // ----------------------------------------
  // SCL hold machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      I2RH_ST_RUN: begin
        if (hold_req) begin
          next_state = I2RH_ST_ARM;
        end
      end
      // Wait for scl low so the ninth high phase is never cut short
      I2RH_ST_ARM: begin
        if (data_rd) begin
          next_state = I2RH_ST_RUN;
        end else if (scl_fall) begin
          next_state = I2RH_ST_HOLD;
        end
      end
      I2RH_ST_HOLD: begin
        if (data_rd) begin
          next_state = I2RH_ST_RUN;
        end
      end
      default: begin
        next_state = I2RH_ST_RUN;
      end
    endcase
    if (init_clr || !module_enable_bit) begin
      next_state = I2RH_ST_RUN;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= I2RH_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Open-drain pins only ever pull low
  assign scl_out = 1'b0;
  assign scl_oe  = (state == I2RH_ST_HOLD);
  assign sda_out = 1'b0;
  assign sda_oe  = ack_drive & rx_mode & module_enable_bit;

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stop_irq_mask     <= 1'b0;
      rx_handshake_en   <= 1'b0;
      module_enable_bit <= 1'b0;
      tx_rx_select      <= 1'b0;
      irq_mask          <= `I2RH_RST_IRQ;
    end else if (wr_en) begin
      if (hit_xc) begin
        stop_irq_mask   <= pwdata[`I2RH_XC_STOP_MASK];
        rx_handshake_en <= pwdata[`I2RH_XC_HANDSHAKE];
      end
      if (hit_ctrl) begin
        module_enable_bit <= pwdata[`I2RH_CT_ENABLE];
        tx_rx_select      <= pwdata[`I2RH_CT_TX_MODE];
      end
      if (hit_mask) begin
        irq_mask <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  logic [1:0] irq_set;
  logic [1:0] irq_w1c;

  assign irq_set[`I2RH_IS_IFACE]   = stop_evt;
  assign irq_set[`I2RH_IS_RX_DONE] = xfer_now | pend_xfer;
  assign irq_w1c = (wr_en & hit_stat) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `I2RH_RST_IRQ;
    end else begin
      // Set beats a simultaneous clear
      irq_status <= (irq_status & ~irq_w1c) | irq_set;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rd_mux;
  logic [7:0]  xc_view;
  logic [7:0]  ctrl_view;

  always_comb begin
    xc_view                        = 8'h00;
    xc_view[`I2RH_XC_STOP_MASK]    = stop_irq_mask;
    xc_view[`I2RH_XC_HANDSHAKE]    = rx_handshake_en;
    xc_view[`I2RH_XC_RX_READY]     = rx_data_ready_flag;
    ctrl_view                      = 8'h00;
    ctrl_view[`I2RH_CT_ENABLE]     = module_enable_bit;
    ctrl_view[`I2RH_CT_TX_MODE]    = tx_rx_select;
    ctrl_view[`I2RH_CT_SCL_HELD]   = scl_oe;
    rd_mux = 32'h0000_0000;
    if (hit_data) begin
      rd_mux[7:0] = rx_buffer;
    end else if (hit_xc) begin
      rd_mux[7:0] = xc_view;
    end else if (hit_ctrl) begin
      rd_mux[7:0] = ctrl_view;
    end else if (hit_stat) begin
      rd_mux[1:0] = irq_status;
    end else if (hit_mask) begin
      rd_mux[1:0] = irq_mask;
    end else if (hit_lclr) begin
      rd_mux[3:0] = `I2RH_CLR_READBACK;
    end
  end

  // Captured in setup so the access phase answers from a flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule
